/* File: rtc_event_comp_reset_ctrl.sv */
// rtc event flags, enables, lost-power, comp_direction compensation and soft reset
// Functional notes
// - alarm match sets event flag bit 15.
// - wake pin event sets event flag bit 5.
// - day, hour, minute, second, millisecond ticks set bits 4 to 0.
// - flags stay set until software writes one; zero writes change nothing.
// - lost-power flag at status bit 0, set after power loss.
// - reading status or event flag register clears lost-power flag.
// - enables for alarm at bit 15 and wake pin at bit 5.
// - enables for day to millisecond at bits 4 to 0.
// - on each hour tick apply signed millisecond correction.
// - zero compensation magnitude means no hourly correction.
// - compensation bit 15 picks direction, 0 subtract, 1 add.
// - magnitude is bcd: bit 12, bits 11-8, 7-4, 3-0.
// - writing one to oscillator bit 15 soft-resets the block.
// - system reset pin leaves the block state untouched.
// - the soft reset bit clears itself once reset is done.
// - oscillator bits 3-0 select resistor, 1011b after reset.
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps

module rtc_event_comp_reset_ctrl #(
   parameter int HOLD_CYCLES = rtc_pkg::SOFT_RESET_HOLD_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic system_reset_n,
   input wire logic wake_pin,
   input wire rtc_pkg::tick_t ticks,
   output logic irq,
   output logic adjust_valid,
   output rtc_pkg::adjust_t adjust,
   output logic [3:0] osc_resistor_sel
);

   localparam int CNT_W = 14;

   // the hold counter must fit its width and count at least one cycle
   generate
      if (HOLD_CYCLES < 1 || HOLD_CYCLES >= (1 << CNT_W)) begin : g_chk
         $error("HOLD_CYCLES out of range");
      end
   endgenerate

   // address match on an aligned word
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   logic [15:0] flags_q, flags_d;
   logic [15:0] en_q, en_d;
   rtc_pkg::comp_t comp_q, comp_d;
   logic [3:0] osc_res_q, osc_res_d;
   logic power_lost_q, power_lost_d;
   logic soft_reset_q, soft_reset_d;
   logic [CNT_W-1:0] hold_cnt_q, hold_cnt_d;
   logic wake_s1_q, wake_s2_q, wake_s3_q;
   logic sys_s1_q, sys_s2_q;
   logic [31:0] prdata_q, prdata_d;
   logic adjust_valid_q, adjust_valid_d;
   rtc_pkg::adjust_t adjust_q, adjust_d;

   // apb phase decode
   wire setup = psel & ~penable;
   wire access = psel & penable;
   wire wr = access & pwrite;
   wire rd = access & ~pwrite;
   wire sel_flag = hit(paddr, rtc_pkg::OFS_EVENT_FLAG);
   wire sel_lost = hit(paddr, rtc_pkg::OFS_LOST_POWER);
   wire sel_en = hit(paddr, rtc_pkg::OFS_EVENT_ENABLE);
   wire sel_comp = hit(paddr, rtc_pkg::OFS_COMPENSATION);
   wire sel_osc = hit(paddr, rtc_pkg::OFS_OSC_CONTROL);
   wire mapped = sel_flag | sel_lost | sel_en | sel_comp | sel_osc;

   // zero wait states; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = access & ~mapped;
   assign prdata = prdata_q;

   // wake pin is asynchronous: edge taken only after the second flop
   wire wake_edge = wake_s2_q & ~wake_s3_q;

   // event vector placed at the documented bit positions
   wire [15:0] set_vec = {
      ticks.alarm,
      9'h000,
      wake_edge,
      ticks.day, ticks.hour, ticks.minute, ticks.second,
      ticks.millisec
   };

   // write-one-to-clear pattern, reserved bits masked out
   wire [15:0] clr_vec = (wr & sel_flag) ?
      (pwdata[15:0] & rtc_pkg::EVENT_MASK) : 16'h0000;

   // soft reset request and its completion
   wire soft_req = wr & sel_osc & pwdata[rtc_pkg::BIT_SOFT_RESET];
   wire soft_done = soft_reset_q & (hold_cnt_q == CNT_W'(1));

   // magnitude in bcd, nonzero check gates the hourly correction
   wire [12:0] comp_bcd = {comp_q.thousands, comp_q.hundreds,
                           comp_q.tens, comp_q.units};
   wire comp_nonzero = (comp_bcd != 13'h0000);

   // interrupt request from any enabled flag
   assign irq = |(flags_q & en_q);

   // event flags: a set in the clear cycle wins over the clear
   assign flags_d = soft_reset_q ? rtc_pkg::EVENT_FLAG_RST :
      (((flags_q & ~clr_vec) | set_vec) & rtc_pkg::EVENT_MASK);

   // enables, reserved bits kept at zero
   assign en_d = soft_reset_q ? rtc_pkg::EVENT_ENABLE_RST :
      (wr & sel_en) ? (pwdata[15:0] & rtc_pkg::EVENT_MASK) :
      en_q;

   // compensation register
   assign comp_d = soft_reset_q ? rtc_pkg::COMP_RST :
      (wr & sel_comp) ? rtc_pkg::comp_t'(pwdata[15:0] & rtc_pkg::COMP_MASK) :
      comp_q;

   // resistor select; a soft reset returns it to the fast-start value
   assign osc_res_d = soft_reset_q ? rtc_pkg::OSC_RES_RST :
      (wr & sel_osc) ?
      pwdata[rtc_pkg::OSC_RES_LSB +: rtc_pkg::OSC_RES_WIDTH] :
      osc_res_q;
   assign osc_resistor_sel = osc_res_q;

   // lost power: set at power-up, cleared by soft reset or by a read
   assign power_lost_d = soft_reset_q ? 1'b0 :
      (rd & (sel_flag | sel_lost)) ? 1'b0 : power_lost_q;

   // soft reset bit holds for the wait time, then drops by itself
   assign soft_reset_d = soft_done ? 1'b0 :
      (soft_req ? 1'b1 : soft_reset_q);
   assign hold_cnt_d = (soft_req & ~soft_reset_q) ? CNT_W'(HOLD_CYCLES) :
      (soft_reset_q ? hold_cnt_q - CNT_W'(1) : hold_cnt_q);

   // hourly correction pulse, none while the block is in soft reset
   assign adjust_valid_d = ticks.hour & comp_nonzero &
      ~soft_reset_q;
   assign adjust_d = adjust_valid_d ?
      rtc_pkg::adjust_t'({comp_q.add, comp_bcd}) : adjust_q;
   assign adjust_valid = adjust_valid_q;
   assign adjust = adjust_q;

   // read data is captured in the setup phase so it sits in a flop
   always_comb begin
      prdata_d = 32'h0000_0000;
      if (sel_flag) begin
         prdata_d[15:0] = flags_q;
      end else if (sel_lost) begin
         prdata_d[rtc_pkg::BIT_POWER_LOST] = power_lost_q;
      end else if (sel_en) begin
         prdata_d[15:0] = en_q;
      end else if (sel_comp) begin
         prdata_d[15:0] = comp_q;
      end else if (sel_osc) begin
         prdata_d[rtc_pkg::BIT_SOFT_RESET] = soft_reset_q;
         prdata_d[rtc_pkg::OSC_RES_LSB +: rtc_pkg::OSC_RES_WIDTH] = osc_res_q;
      end
   end

   // block state: presetn is the power-up of the rtc domain only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_q <= rtc_pkg::EVENT_FLAG_RST;
         en_q <= rtc_pkg::EVENT_ENABLE_RST;
         comp_q <= rtc_pkg::COMP_RST;
         osc_res_q <= rtc_pkg::OSC_RES_RST;
         power_lost_q <= rtc_pkg::POWER_LOST_RST;
         soft_reset_q <= 1'b0;
         hold_cnt_q <= '0;
      end else begin
         flags_q <= flags_d;
         en_q <= en_d;
         comp_q <= comp_d;
         osc_res_q <= osc_res_d;
         power_lost_q <= power_lost_d;
         soft_reset_q <= soft_reset_d;
         hold_cnt_q <= hold_cnt_d;
      end
   end

   // pin synchronisers for the wake pin and the system reset pin
   // each copy resets to its pin's idle level: low for the wake pin, high
   // for the system reset pin, so a release of presetn shows no false edge
   // and no false reset request that would blank the first read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_s1_q <= 1'b0;
         wake_s2_q <= 1'b0;
         wake_s3_q <= 1'b0;
         sys_s1_q <= 1'b1;
         sys_s2_q <= 1'b1;
      end else begin
         wake_s1_q <= wake_pin;
         wake_s2_q <= wake_s1_q;
         wake_s3_q <= wake_s2_q;
         sys_s1_q <= system_reset_n;
         sys_s2_q <= sys_s1_q;
      end
   end

   // system reset only clears the bus-side read buffer, never rtc state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (!sys_s2_q) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup) begin
         prdata_q <= prdata_d;
      end
   end

   // correction output flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adjust_valid_q <= 1'b0;
         adjust_q <= '0;
      end else begin
         adjust_valid_q <= adjust_valid_d;
         adjust_q <= adjust_d;
      end
   end

   // checks on the guarded behaviour

   a_alarm_sets_flag: assert property (
      @(posedge pclk) disable iff (!presetn)
      ticks.alarm && !soft_reset_q |=> flags_q[rtc_pkg::BIT_ALARM] && irq ==
         en_q[rtc_pkg::BIT_ALARM] || |(flags_q[5:0] & en_q[5:0]))
      else $error("alarm tick did not set its flag");

   a_wake_edge_flag: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(wake_s2_q) && !soft_reset_q |=> flags_q[rtc_pkg::BIT_WAKE])
      else $error("wake pin edge did not set its flag");

   a_tick_sets_flag: assert property (
      @(posedge pclk) disable iff (!presetn)
      ticks.minute && !soft_reset_q |=> ##1 flags_q[rtc_pkg::BIT_MINUTE]
         || $past(clr_vec[rtc_pkg::BIT_MINUTE]))
      else $error("minute tick flag lost");

   a_flag_w1c_clear: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr && sel_flag && pwdata[rtc_pkg::BIT_SECOND] && !ticks.second &&
         !soft_reset_q |=> !flags_q[rtc_pkg::BIT_SECOND])
      else $error("write one did not clear the flag");

   a_flag_zero_keep: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr && sel_flag && !pwdata[rtc_pkg::BIT_HOUR] &&
         flags_q[rtc_pkg::BIT_HOUR] && !soft_reset_q
         |=> flags_q[rtc_pkg::BIT_HOUR])
      else $error("write zero changed a flag");

   a_lost_read_clear: assert property (
      @(posedge pclk) disable iff (!presetn)
      rd && (sel_lost || sel_flag) |=> !power_lost_q [*2])
      else $error("read did not clear lost-power flag");

   a_irq_gating: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(flags_q[rtc_pkg::BIT_DAY]) && en_q[rtc_pkg::BIT_DAY] |-> irq)
      else $error("enabled flag gave no interrupt");

   a_comp_zero_none: assert property (
      @(posedge pclk) disable iff (!presetn)
      ticks.hour && !comp_nonzero |=> !adjust_valid)
      else $error("correction applied with zero magnitude");

   a_comp_hour_apply: assert property (
      @(posedge pclk) disable iff (!presetn)
      ticks.hour && comp_nonzero && !soft_reset_q |=> adjust_valid &&
         adjust.add == $past(comp_q.add) && adjust.bcd == $past(comp_bcd))
      else $error("hourly correction missing or wrong");

   a_soft_self_clear: assert property (
      @(posedge pclk) disable iff (!presetn)
      soft_done |=> !soft_reset_q && osc_res_q == rtc_pkg::OSC_RES_RST &&
         comp_q == rtc_pkg::COMP_RST && en_q == rtc_pkg::EVENT_ENABLE_RST)
      else $error("soft reset did not finish cleanly");

   a_soft_hold_count: assert property (
      @(posedge pclk) disable iff (!presetn)
      soft_req && !soft_reset_q |=> soft_reset_q &&
         hold_cnt_q == CNT_W'(HOLD_CYCLES))
      else $error("soft reset not started");

   a_sysreset_keeps: assert property (
      @(posedge pclk) disable iff (!presetn)
      !sys_s2_q && !wr && !soft_reset_q |=> $stable(en_q) &&
         $stable(comp_q) && $stable(osc_res_q))
      else $error("system reset disturbed rtc state");

   a_reserved_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      setup && sys_s2_q && sel_comp |=> prdata_q[31:16] == 16'h0000 &&
         prdata_q[14:13] == 2'b00)
      else $error("reserved bits read nonzero");

   a_lost_power_holds: assert property (
      @(posedge pclk) disable iff (!presetn)
      power_lost_q && !soft_reset_q && !(rd && (sel_flag || sel_lost))
         |=> power_lost_q)
      else $error("lost-power flag dropped without a read");

   a_soft_drops_state: assert property (
      @(posedge pclk) disable iff (!presetn)
      soft_reset_q |=> flags_q == rtc_pkg::EVENT_FLAG_RST &&
         !power_lost_q && !adjust_valid)
      else $error("soft reset left block state behind");

   a_enable_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr && sel_en && !soft_reset_q |=>
         en_q == ($past(pwdata[15:0]) & rtc_pkg::EVENT_MASK))
      else $error("enable write did not land");

   a_comp_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr && sel_comp && !soft_reset_q |=>
         comp_q == ($past(pwdata[15:0]) & rtc_pkg::COMP_MASK))
      else $error("compensation write did not land");

   a_resistor_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr && sel_osc && !soft_reset_q && !pwdata[rtc_pkg::BIT_SOFT_RESET]
         |=> osc_res_q ==
         $past(pwdata[rtc_pkg::OSC_RES_LSB +: rtc_pkg::OSC_RES_WIDTH]))
      else $error("resistor select write did not land");

endmodule

/* File: rtc_pkg.sv */
// constants, field layouts and carrier types of the rtc event block
package rtc_pkg;

   // register byte offsets on the apb
   localparam logic [7:0] OFS_EVENT_FLAG = 8'h00;
   localparam logic [7:0] OFS_LOST_POWER = 8'h04;
   localparam logic [7:0] OFS_EVENT_ENABLE = 8'h08;
   localparam logic [7:0] OFS_COMPENSATION = 8'h0C;
   localparam logic [7:0] OFS_OSC_CONTROL = 8'h10;

   // bit positions of event flags and enables, the lost-power and soft reset bits and the resistor field
   localparam int BIT_ALARM = 15;
   localparam int BIT_WAKE = 5;
   localparam int BIT_DAY = 4;
   localparam int BIT_HOUR = 3;
   localparam int BIT_MINUTE = 2;
   localparam int BIT_SECOND = 1;
   localparam int BIT_MILLISEC = 0;
   localparam int BIT_POWER_LOST = 0;
   localparam int BIT_SOFT_RESET = 15;
   localparam int OSC_RES_LSB = 0;
   localparam int OSC_RES_WIDTH = 4;

   // writable bit masks, reserved bits clear
   localparam logic [15:0] EVENT_MASK = 16'h803F;
   localparam logic [15:0] COMP_MASK = 16'h9FFF;

   // reset values
   localparam logic [15:0] EVENT_FLAG_RST = 16'h0000;
   localparam logic [15:0] EVENT_ENABLE_RST = 16'h0000;
   localparam logic [15:0] COMP_RST = 16'h0000;
   localparam logic [3:0] OSC_RES_RST = 4'hB;
   localparam logic POWER_LOST_RST = 1'b1;

   // soft reset hold: three slow-clock cycles, rounded up in pclk cycles
   localparam int PCLK_HZ = 125_000_000;
   localparam int SLOW_CLK_HZ = 32_768;
   localparam int SOFT_RESET_SLOW_CYCLES = 3;
   localparam int SOFT_RESET_HOLD_CYCLES =
      (SOFT_RESET_SLOW_CYCLES * PCLK_HZ + SLOW_CLK_HZ - 1) / SLOW_CLK_HZ;

   // compensation register layout
   typedef struct packed {
      logic add;
      logic [1:0] rsvd;
      logic thousands;
      logic [3:0] hundreds;
      logic [3:0] tens;
      logic [3:0] units;
   } comp_t;

   // periodic and alarm strobes from the calendar logic
   typedef struct packed {
      logic alarm;
      logic day;
      logic hour;
      logic minute;
      logic second;
      logic millisec;
   } tick_t;

   // hourly millisecond correction towards the millisecond counter
   typedef struct packed {
      logic add;
      logic [12:0] bcd;
   } adjust_t;

endpackage

/* File: rtc_event_comp_reset_ctrl_tb.sv */
// self-checking bench for the rtc event, compensation and reset block
`timescale 1ns/1ps
module rtc_event_comp_reset_ctrl_tb;
   localparam int HOLD = 8;
   typedef struct packed {logic [31:0] d; logic e;} rd_t;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, system_reset_n = 1'b1, wake_pin = 1'b0;
   logic chk_irq = 1'b0, irq, pready, pslverr, adjust_valid;
   logic chk_osc = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000, prdata;
   logic [3:0] osc_resistor_sel;
   logic [15:0] c;
   rtc_pkg::tick_t ticks = 6'h00;
   rtc_pkg::adjust_t adjust;
   rtc_pkg::comp_t cv;
   rd_t rdq[$];
   rtc_pkg::adjust_t adjq[$];
   logic irqq[$];
   logic [3:0] oscq[$];
   int error_cnt = 0, n_tests = 0, cyc = 0;

   // a short hold keeps the soft reset wait within a few cycles
   rtc_event_comp_reset_ctrl #(.HOLD_CYCLES(HOLD)) dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .system_reset_n(system_reset_n),
      .wake_pin(wake_pin), .ticks(ticks), .irq(irq),
      .adjust_valid(adjust_valid), .adjust(adjust),
      .osc_resistor_sel(osc_resistor_sel));

   always #4 pclk = ~pclk;

   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic cmp(input string n, input logic [32:0] e, g);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic chk_rd(input rd_t e, g); cmp("read", e, g); endtask
   task automatic chk_adj(input rtc_pkg::adjust_t e, g);
      cmp("adjust", 33'(e), 33'(g));
   endtask
   task automatic chk_irq_val(input logic e, g); cmp("irq", e, g); endtask
   task automatic chk_osc_val(input logic [3:0] e, g);
      cmp("osc_sel", 33'(e), 33'(g));
   endtask

   // scoreboard: oldest note is popped whenever a result shows up
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         chk_rd(rdq.pop_front(), {prdata, pslverr});
      end
      if (adjust_valid === 1'b1) begin
         if (adjq.size() == 0) begin
            error_cnt++;
            $display("mismatch adjust exp none got %h", adjust);
         end else begin
            chk_adj(adjq.pop_front(), adjust);
         end
      end
      if (chk_irq) begin
         chk_irq_val(irqq.pop_front(), irq);
      end
      if (chk_osc) begin
         chk_osc_val(oscq.pop_front(), osc_resistor_sel);
      end
   end

   // hang guard: the whole run needs well under this many cycles
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         results();
      end
   end

   // apb master: holds the request until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic e = 1'b0);
      rdq.push_back({d, e});
      apb(1'b0, a, 32'h00000000);
   endtask
   task automatic tick(input logic [5:0] t);
      ticks <= t;
      @(posedge pclk);
      ticks <= 6'h00;
      @(posedge pclk);
   endtask
   task automatic irq_is(input logic e);
      irqq.push_back(e);
      chk_irq <= 1'b1;
      @(posedge pclk);
      chk_irq <= 1'b0;
   endtask
   task automatic osc_is(input logic [3:0] e);
      oscq.push_back(e);
      chk_osc <= 1'b1;
      @(posedge pclk);
      chk_osc <= 1'b0;
   endtask
   task automatic power_up();
      presetn <= 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask

   // main sequence
   initial begin
      void'($urandom(20802));
      power_up();
      rd(rtc_pkg::OFS_LOST_POWER, 32'h00000001);
      rd(rtc_pkg::OFS_LOST_POWER, 32'h00000000);
      rd(rtc_pkg::OFS_OSC_CONTROL, 32'h0000000B);
      osc_is(4'hB);
      rd(rtc_pkg::OFS_EVENT_ENABLE, 32'h00000000);
      rd(8'h14, 32'h00000000, 1'b1);
      power_up();
      rd(rtc_pkg::OFS_EVENT_FLAG, 32'h00000000);
      rd(rtc_pkg::OFS_LOST_POWER, 32'h00000000);
      $display("test reset done");
      wr(rtc_pkg::OFS_EVENT_ENABLE, 32'hFFFFFFFF);
      rd(rtc_pkg::OFS_EVENT_ENABLE, 32'h0000803F);
      // each tick source and the alarm in turn; zero writes must not clear
      for (int i = 0; i < 6; i++) begin
         c = (i == 5) ? 16'h8000 : 16'h0001 << i;
         tick(6'h01 << i);
         irq_is(1'b1);
         wr(rtc_pkg::OFS_EVENT_FLAG, {16'h0000, ~c});
         rd(rtc_pkg::OFS_EVENT_FLAG, {16'h0000, c});
         wr(rtc_pkg::OFS_EVENT_FLAG, {16'h0000, c});
         rd(rtc_pkg::OFS_EVENT_FLAG, 32'h00000000);
         irq_is(1'b0);
      end
      wake_pin <= 1'b1;
      repeat (6) @(posedge pclk);
      rd(rtc_pkg::OFS_EVENT_FLAG, 32'h00000020);
      wake_pin <= 1'b0;
      wr(rtc_pkg::OFS_EVENT_ENABLE, 32'h00000002);
      tick(6'h04);
      irq_is(1'b0);
      tick(6'h02);
      irq_is(1'b1);
      wr(rtc_pkg::OFS_EVENT_FLAG, 32'h0000803F);
      $display("test events done");
      // random signed bcd corrections, reserved bits written as noise
      for (int k = 0; k < 6; k++) begin
         cv = 16'($urandom);
         cv.hundreds = 4'($urandom % 10);
         cv.tens = 4'($urandom % 10);
         cv.units = 4'($urandom % 9 + 1);
         wr(rtc_pkg::OFS_COMPENSATION, {16'h0000, cv});
         rd(rtc_pkg::OFS_COMPENSATION, {16'h0000, cv & 16'h9FFF});
         adjq.push_back(rtc_pkg::adjust_t'({cv.add, cv[12:0]}));
         tick(6'h08);
      end
      wr(rtc_pkg::OFS_COMPENSATION, 32'h00008000);
      tick(6'h08);
      $display("test compensation done");
      wr(rtc_pkg::OFS_OSC_CONTROL, 32'h00000008);
      rd(rtc_pkg::OFS_OSC_CONTROL, 32'h00000008);
      osc_is(4'h8);
      system_reset_n <= 1'b0;
      repeat (4) @(posedge pclk);
      system_reset_n <= 1'b1;
      repeat (4) @(posedge pclk);
      rd(rtc_pkg::OFS_EVENT_FLAG, 32'h00000008);
      rd(rtc_pkg::OFS_OSC_CONTROL, 32'h00000008);
      rd(rtc_pkg::OFS_COMPENSATION, 32'h00008000);
      wr(rtc_pkg::OFS_COMPENSATION, 32'h00000123);
      wr(rtc_pkg::OFS_OSC_CONTROL, 32'h00008008);
      tick(6'h01);
      repeat (HOLD + 4) @(posedge pclk);
      rd(rtc_pkg::OFS_OSC_CONTROL, 32'h0000000B);
      osc_is(4'hB);
      rd(rtc_pkg::OFS_EVENT_FLAG, 32'h00000000);
      rd(rtc_pkg::OFS_EVENT_ENABLE, 32'h00000000);
      rd(rtc_pkg::OFS_COMPENSATION, 32'h00000000);
      rd(rtc_pkg::OFS_LOST_POWER, 32'h00000000);
      cmp("notes left", 33'h0, 33'(rdq.size() + adjq.size()));
      $display("test soft reset done");
      results();
   end
endmodule
